// [shared/rcf_pkg.sv]
package rcf_pkg;

  // ==========================================================================
  // Channel counts and clocking
  localparam int RCF_NCH      = 7;
  localparam int RCF_NSW      = 3;
  localparam int RCF_CLK_HZ   = 125000000;
  localparam int RCF_MS_PER_S = 1000;
  localparam int RCF_MS_CYCLES = RCF_CLK_HZ / RCF_MS_PER_S;

  // ==========================================================================
  // Bus map
  localparam int         RCF_DW         = 32;
  localparam int         RCF_BYTE       = 8;
  localparam int         RCF_LANES      = 4;
  localparam int         RCF_ADR_CH_LSB = 3;
  localparam int         RCF_ADR_CH_W   = 3;
  localparam logic [2:0] RCF_CTRL_OFS   = 3'h0;
  localparam logic [2:0] RCF_STAT_OFS   = 3'h4;
  localparam logic [1:0] RCF_ADR_TOP0   = 2'h0;

  // ==========================================================================
  // Control word fields
  localparam int RCF_CODE_W   = 6;
  localparam int RCF_DLY_W    = 3;
  localparam int RCF_MV_W     = 12;
  localparam int RCF_F_CODE_A = 0;
  localparam int RCF_F_CODE_B = 6;
  localparam int RCF_F_ON     = 12;
  localparam int RCF_F_DLY    = 13;
  localparam int RCF_F_IRQEN  = 16;
  localparam int RCF_F_DIS    = 17;
  localparam int RCF_F_LOWB   = 18;
  localparam logic [31:0] RCF_SW_MASK  = 32'h0001FFFF;
  localparam logic [31:0] RCF_LIN_MASK = 32'h0007F03F;

  // Status word fields
  localparam int RCF_S_PG  = 0;
  localparam int RCF_S_EN  = 1;
  localparam int RCF_S_FLT = 2;

  // ==========================================================================
  // Voltage codes and targets in millivolts
  localparam logic [RCF_CODE_W-1:0] RCF_DEF_CODE [RCF_NCH] =
    '{6'h1C, 6'h12, 6'h2C, 6'h2F, 6'h2F, 6'h1C, 6'h3C};
  localparam logic [RCF_MV_W-1:0] RCF_BASE_MV [8] =
    '{12'h258, 12'h320, 12'h3E8, 12'h4B0, 12'h640, 12'h7D0, 12'h960, 12'hC80};
  localparam logic [RCF_MV_W-1:0] RCF_STEP_MV [8] =
    '{12'h019, 12'h019, 12'h019, 12'h032, 12'h032, 12'h032, 12'h064, 12'h064};
  localparam logic [RCF_MV_W-1:0] RCF_MV_MIN = 12'h258;
  localparam logic [RCF_MV_W-1:0] RCF_MV_MAX = 12'hF3C;

  typedef enum logic [1:0] {
    RCF_OFF  = 2'b00,
    RCF_WAIT = 2'b01,
    RCF_ON   = 2'b10
  } rcf_state_e;

  function automatic logic [RCF_MV_W-1:0] rcf_code_to_mv(input logic [RCF_CODE_W-1:0] code);
    logic [RCF_MV_W-1:0] prod;
    prod = RCF_MV_W'(RCF_STEP_MV[code[5:3]] * {9'h000, code[2:0]});
    return RCF_BASE_MV[code[5:3]] + prod;
  endfunction

  function automatic logic [31:0] rcf_wmask(input int idx);
    return (idx < RCF_NSW) ? RCF_SW_MASK : RCF_LIN_MASK;
  endfunction

  function automatic logic [31:0] rcf_rst_word(input int idx);
    logic [31:0] w;
    w = {20'h00000, RCF_DEF_CODE[idx], RCF_DEF_CODE[idx]};
    return w & rcf_wmask(idx);
  endfunction

endpackage

// [shared/rcf_ch_if.sv]
`timescale 1ns/10ps
interface rcf_ch_if;
  import rcf_pkg::*;

  logic [RCF_DW-1:0]   ctrl;
  logic                pg;
  logic                bank_sel;
  logic                stat_rd;
  logic                enabled;
  logic                fault;
  logic [RCF_MV_W-1:0] mv;
  logic                discharge;
  logic                low_bias;

  modport top (output ctrl, pg, bank_sel, stat_rd,
               input  enabled, fault, mv, discharge, low_bias);
  modport chan (input  ctrl, pg, bank_sel, stat_rd,
                output enabled, fault, mv, discharge, low_bias);
endinterface

// [verilog/rcf_channel.sv]
`timescale 1ns/10ps
module rcf_channel
  import rcf_pkg::*;
#(
  parameter bit IS_LINEAR = 1'b0,
  parameter int MS_CYCLES = RCF_MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  rcf_ch_if.chan   ch
);

  // ==========================================================================
  // State
  rcf_state_e          state_ff, nxt_state;
  logic                on_prev_ff, nxt_on_prev;
  logic [31:0]         cnt_ff, nxt_cnt;
  logic                en_ff, nxt_en;
  logic                fault_ff, nxt_fault;
  logic                seen_ff, nxt_seen;
  logic [RCF_MV_W-1:0] mv_ff, nxt_mv;
  logic                dis_ff, nxt_dis;
  logic                lowb_ff, nxt_lowb;

  logic                  on_bit;
  logic [RCF_DLY_W-1:0]  dly;
  logic [31:0]           target;
  logic [RCF_CODE_W-1:0] code;
  logic                  fault_now;
  logic                  release_ok;

  assign on_bit = ch.ctrl[RCF_F_ON];
  assign dly    = ch.ctrl[RCF_F_DLY +: RCF_DLY_W];
  // Zero code means no wait, else 2^code milliseconds
  assign target = (dly == '0) ? 32'h0 : (32'(MS_CYCLES) << dly); // R14
  // Switching channels pick their code bank from the pin
  assign code = (!IS_LINEAR && ch.bank_sel) ? ch.ctrl[RCF_F_CODE_B +: RCF_CODE_W]
                                            : ch.ctrl[RCF_F_CODE_A +: RCF_CODE_W]; // R13
  assign fault_now  = (state_ff == RCF_ON) && ch.ctrl[RCF_F_IRQEN] && !ch.pg; // R2 R6
  assign release_ok = seen_ff && ((state_ff != RCF_ON) || ch.pg); // R3

  // ==========================================================================
  // On/off sequencing
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_on_prev = on_bit;
    case (state_ff)
      RCF_OFF: begin
        if (on_bit && !on_prev_ff) begin // R8
          nxt_state = RCF_WAIT;
          nxt_cnt   = 32'h0;
        end
      end
      RCF_WAIT: begin
        if (cnt_ff >= target) begin // R10
          nxt_state = RCF_ON;
        end else begin
          nxt_cnt = cnt_ff + 32'h1;
        end
      end
      RCF_ON: begin
        nxt_state = RCF_ON;
      end
      default: begin
        nxt_state = RCF_OFF;
      end
    endcase
    if (!on_bit && on_prev_ff) begin // R8
      nxt_state = RCF_OFF;
      nxt_cnt   = 32'h0;
    end
    nxt_en = (nxt_state == RCF_ON);
  end

  // ==========================================================================
  // Fault latch and analog controls
  always_comb begin
    nxt_fault = fault_now || (fault_ff && !release_ok); // R3
    nxt_seen  = nxt_fault && (seen_ff || (ch.stat_rd && fault_ff)); // R3
    nxt_mv    = rcf_code_to_mv(code); // R4 R7
    nxt_dis   = IS_LINEAR && ch.ctrl[RCF_F_DIS] && (nxt_state != RCF_ON); // R11
    nxt_lowb  = IS_LINEAR && ch.ctrl[RCF_F_LOWB]; // R12
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff   <= RCF_OFF;
      on_prev_ff <= 1'b0;
      cnt_ff     <= 32'h0;
      en_ff      <= 1'b0;
      fault_ff   <= 1'b0;
      seen_ff    <= 1'b0;
      mv_ff      <= RCF_MV_MIN;
      dis_ff     <= 1'b0;
      lowb_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      on_prev_ff <= nxt_on_prev;
      cnt_ff     <= nxt_cnt;
      en_ff      <= nxt_en;
      fault_ff   <= nxt_fault;
      seen_ff    <= nxt_seen;
      mv_ff      <= nxt_mv;
      dis_ff     <= nxt_dis;
      lowb_ff    <= nxt_lowb;
    end
  end

  assign ch.enabled   = en_ff;
  assign ch.fault     = fault_ff;
  assign ch.mv        = mv_ff;
  assign ch.discharge = dis_ff;
  assign ch.low_bias  = lowb_ff;

endmodule // rcf_channel

// [verilog/rcf_regulator_ctrl.sv]
// Behaviour
// R1 - Switching power-good flag low below threshold
// R2 - Enabled switching fault raises host interrupt
// R3 - Interrupt holds until recovered and flag read
// R4 - Six-bit code maps coarse/fine to voltage
// R5 - Linear power-good flag low below threshold
// R6 - Enabled linear fault raises host interrupt
// R7 - Default voltage at reset, codes independently writable
// R8 - On bit edges turn channel on/off
// R9 - Host toggles on bit to make edges
// R10 - Linear channel waits programmed delay before enabling
// R11 - Discharge output while disabled when bit set
// R12 - Low-bias mode selected when bit set
// R13 - Bank pin selects switching voltage code
// R14 - Delay code: zero, then 2 to 128 ms
// R15 - Interrupt low while any enabled fault pending
`timescale 1ns/10ps
module rcf_regulator_ctrl
  import rcf_pkg::*;
#(
  parameter int MS_CYCLES = RCF_MS_CYCLES
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic [7:0]                   adr_i,
  input  wire logic [RCF_DW-1:0]            dat_i,
  output logic      [RCF_DW-1:0]            dat_o,
  input  wire logic [RCF_LANES-1:0]         sel_i,
  input  wire logic                         we_i,
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  output logic                              ack_o,
  input  wire logic [RCF_NCH-1:0]           pg_raw_i,
  input  wire logic                         voltage_bank_select_pin_i,
  output logic      [RCF_NCH-1:0]           ch_enable_o,
  output logic      [RCF_NCH*RCF_MV_W-1:0]  target_mv_o,
  output logic      [RCF_NCH-RCF_NSW-1:0]   output_discharge_enable_o,
  output logic      [RCF_NCH-RCF_NSW-1:0]   low_bias_enable_o,
  output logic                              host_interrupt_low_o
);

  localparam int SYNC_W = RCF_NCH + 1;

  // ==========================================================================
  // Pin synchronisers
  logic [SYNC_W-1:0] meta_ff, nxt_meta;
  logic [SYNC_W-1:0] sync_ff, nxt_sync;
  logic [RCF_NCH-1:0] pg_sync;
  logic               bank_sync;

  always_comb begin
    nxt_meta = {voltage_bank_select_pin_i, pg_raw_i};
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign pg_sync   = sync_ff[RCF_NCH-1:0]; // R1 R5
  assign bank_sync = sync_ff[RCF_NCH]; // R13

  // ==========================================================================
  // Wishbone slave
  logic [RCF_DW-1:0]       ctrl_ff [RCF_NCH];
  logic [RCF_DW-1:0]       nxt_ctrl [RCF_NCH];
  logic                    ack_ff, nxt_ack;
  logic [RCF_DW-1:0]       dat_ff, nxt_dat;
  logic [RCF_NCH-1:0]      stat_rd_ff, nxt_stat_rd;
  logic [RCF_NCH-1:0]      en_vec;
  logic [RCF_NCH-1:0]      flt_vec;
  logic [RCF_ADR_CH_W-1:0] ch_sel;
  logic [2:0]              reg_ofs;
  logic                    bus_hit;
  logic                    adr_ok;
  logic                    is_ctrl;
  logic                    is_stat;
  logic                    irq_low_ff, nxt_irq_low;

  assign ch_sel  = adr_i[RCF_ADR_CH_LSB +: RCF_ADR_CH_W];
  assign reg_ofs = adr_i[RCF_ADR_CH_LSB-1:0];
  assign bus_hit = cyc_i && stb_i && !ack_ff;
  assign is_ctrl = (reg_ofs == RCF_CTRL_OFS);
  assign is_stat = (reg_ofs == RCF_STAT_OFS);
  assign adr_ok  = (adr_i[RCF_ADR_CH_LSB + RCF_ADR_CH_W +: $bits(RCF_ADR_TOP0)] == RCF_ADR_TOP0)
                   && (32'(ch_sel) < RCF_NCH)
                   && (is_ctrl || is_stat);

  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_ack     = bus_hit;
    nxt_dat     = '0;
    nxt_stat_rd = '0;
    if (bus_hit && adr_ok) begin
      if (we_i && is_ctrl) begin
        // Each channel's codes and bits are written on their own
        for (int b = 0; b < RCF_LANES; b++) begin
          if (sel_i[b]) begin
            nxt_ctrl[ch_sel][RCF_BYTE*b +: RCF_BYTE] = dat_i[RCF_BYTE*b +: RCF_BYTE]; // R7
          end
        end
        nxt_ctrl[ch_sel] = nxt_ctrl[ch_sel] & rcf_wmask(32'(ch_sel));
      end else if (!we_i && is_ctrl) begin
        nxt_dat = ctrl_ff[ch_sel];
      end else if (!we_i) begin
        nxt_dat[RCF_S_PG]    = pg_sync[ch_sel]; // R1 R5
        nxt_dat[RCF_S_EN]    = en_vec[ch_sel];
        nxt_dat[RCF_S_FLT]   = flt_vec[ch_sel];
        nxt_stat_rd[ch_sel]  = 1'b1; // R3
      end
    end
    nxt_irq_low = !(|flt_vec); // R15
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < RCF_NCH; i++) begin
        ctrl_ff[i] <= rcf_rst_word(i); // R7
      end
      ack_ff     <= 1'b0;
      dat_ff     <= '0;
      stat_rd_ff <= '0;
      irq_low_ff <= 1'b1;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      ack_ff     <= nxt_ack;
      dat_ff     <= nxt_dat;
      stat_rd_ff <= nxt_stat_rd;
      irq_low_ff <= nxt_irq_low;
    end
  end

  assign ack_o                = ack_ff;
  assign dat_o                = dat_ff;
  assign host_interrupt_low_o = irq_low_ff;

  // ==========================================================================
  // Channels
  rcf_ch_if ch_if [RCF_NCH] ();

  // Assertion helper: a status read since the fault was raised
  logic [RCF_NCH-1:0] rd_seen_ff;
  logic [RCF_NCH-1:0] nxt_rd_seen;

  always_comb begin
    nxt_rd_seen = rd_seen_ff & flt_vec;
    nxt_rd_seen = nxt_rd_seen | (stat_rd_ff & flt_vec);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_seen_ff <= '0;
    end else begin
      rd_seen_ff <= nxt_rd_seen;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  for (genvar g = 0; g < RCF_NCH; g++) begin : g_ch
    localparam bit LIN = (g >= RCF_NSW);

    assign ch_if[g].ctrl     = ctrl_ff[g];
    assign ch_if[g].pg       = pg_sync[g];
    assign ch_if[g].bank_sel = bank_sync;
    assign ch_if[g].stat_rd  = stat_rd_ff[g];
    assign en_vec[g]         = ch_if[g].enabled;
    assign flt_vec[g]        = ch_if[g].fault;
    assign ch_enable_o[g]    = ch_if[g].enabled;
    assign target_mv_o[g*RCF_MV_W +: RCF_MV_W] = ch_if[g].mv;

    rcf_channel #(
      .IS_LINEAR (LIN),
      .MS_CYCLES (MS_CYCLES)
    ) u_ch (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ch    (ch_if[g])
    );

    if (LIN) begin : g_lin
      assign output_discharge_enable_o[g-RCF_NSW] = ch_if[g].discharge; // R11
      assign low_bias_enable_o[g-RCF_NSW]         = ch_if[g].low_bias; // R12
    end

    // ------------------------------------------------------------------------
    // Channel checks
    sequence s_rise_nodly;
      $rose(ctrl_ff[g][RCF_F_ON]) && (ctrl_ff[g][RCF_F_DLY +: RCF_DLY_W] == '0)
      ##1 ctrl_ff[g][RCF_F_ON];
    endsequence

    sequence s_rise_dly;
      $rose(ctrl_ff[g][RCF_F_ON]) && (ctrl_ff[g][RCF_F_DLY +: RCF_DLY_W] != '0);
    endsequence

    AST_FAULT_SET: assert property ( // R2 R6
      (ch_if[g].enabled && ctrl_ff[g][RCF_F_IRQEN] && !pg_sync[g] && ch_enable_o[g])
      |=> ch_if[g].fault ##1 !host_interrupt_low_o)
      else $error("enabled fault did not raise the interrupt");

    AST_FAULT_HOLD: assert property ( // R3
      $fell(ch_if[g].fault) |-> $past(rd_seen_ff[g])
        && ($past(pg_sync[g]) || !$past(ch_if[g].enabled)))
      else $error("fault released without read and recovery");

    AST_TURN_ON: assert property ( // R8
      s_rise_nodly |=> ch_if[g].enabled)
      else $error("rising on bit did not enable channel");

    AST_DELAY_WAIT: assert property ( // R10
      s_rise_dly |=> !ch_if[g].enabled [*3])
      else $error("channel enabled before its delay");

    AST_TURN_OFF: assert property ( // R8
      $fell(ctrl_ff[g][RCF_F_ON]) |=> !ch_if[g].enabled)
      else $error("falling on bit did not disable channel");

    AST_PG_READ: assert property ( // R1 R5
      nxt_stat_rd[g] |=> dat_o[RCF_S_PG] == $past(pg_sync[g]) && ack_o)
      else $error("status read returned wrong power-good flag");

    AST_MV_RANGE: assert property ( // R4
      $past(rst_i) == 1'b0 |-> ch_if[g].mv >= RCF_MV_MIN && ch_if[g].mv <= RCF_MV_MAX)
      else $error("target voltage out of range");

    if (LIN) begin : g_lin_chk
      AST_DISCHARGE: assert property ( // R11
        ch_if[g].discharge |-> !ch_if[g].enabled && $past(ctrl_ff[g][RCF_F_DIS]))
        else $error("discharge applied while enabled or not requested");

      AST_LOW_BIAS: assert property ( // R12
        ctrl_ff[g][RCF_F_LOWB] |=> ch_if[g].low_bias)
        else $error("low-bias mode not selected");
    end else begin : g_sw_chk
      AST_BANK_B: assert property ( // R13
        bank_sync |=> ch_if[g].mv == rcf_code_to_mv($past(ctrl_ff[g][RCF_F_CODE_B +: RCF_CODE_W])))
        else $error("switching channel ignored bank select");
    end
  end

  // ==========================================================================
  // Global checks
  AST_IRQ_LOW: assert property ( // R15
    (|flt_vec) |=> !host_interrupt_low_o)
    else $error("pending fault did not drive interrupt low");

  AST_IRQ_IDLE: assert property ( // R15
    !(|flt_vec) |=> host_interrupt_low_o)
    else $error("interrupt low with no pending fault");

  AST_ACK_PULSE: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

endmodule // rcf_regulator_ctrl

// [tb/rcf_host_model.sv]
`timescale 1ns/10ps
// ==========================================================================
// Host side: issues classic single bus cycles
module rcf_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic      [7:0]  adr_o,
  output logic      [31:0] dat_o,
  output logic      [3:0]  sel_o,
  output logic             we_o,
  output logic             cyc_o,
  output logic             stb_o
);
  initial begin
    adr_o = 8'h00;
    dat_o = 32'h0;
    sel_o = 4'h0;
    we_o  = 1'b0;
    cyc_o = 1'b0;
    stb_o = 1'b0;
  end

  // Request held until ack is sampled, then released for at least two cycles before the next request
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    adr_o <= a;
    dat_o <= d;
    sel_o <= s;
    we_o  <= w;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    @(posedge clk_i);
    while (ack_i !== 1'b1) begin
      @(posedge clk_i);
    end
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule // rcf_host_model

// [tb/rcf_regulator_ctrl_tb.sv]
`timescale 1ns/10ps
// ==========================================================================
// Bench for the regulator control bank
module rcf_regulator_ctrl_tb;
  import rcf_pkg::*;

  localparam int MS = 4;
  localparam int BASE_MV [8] = '{600, 800, 1000, 1200, 1600, 2000, 2400, 3200};
  localparam int STEP_MV [8] = '{25, 25, 25, 50, 50, 50, 100, 100};
  localparam logic [7:0] BAD_ADR [4] = '{8'h38, 8'h3C, 8'h0A, 8'h40};

  logic                        clk_i;
  logic                        rst_i;
  logic [7:0]                  adr;
  logic [31:0]                 wdat;
  logic [31:0]                 rdat;
  logic [3:0]                  sel;
  logic                        we;
  logic                        cyc;
  logic                        stb;
  logic                        ack;
  logic [RCF_NCH-1:0]          pg_raw;
  logic                        bank_pin;
  logic [RCF_NCH-1:0]          ch_en;
  logic [RCF_NCH*RCF_MV_W-1:0] tmv;
  logic [3:0]                  dis;
  logic [3:0]                  lowb;
  logic                        irq_n;
  int                          num_errors;
  int                          checks_done;
  int                          mdl_ctrl [RCF_NCH];

  rcf_regulator_ctrl #(.MS_CYCLES(MS)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .dat_o(rdat),
    .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
    .pg_raw_i(pg_raw), .voltage_bank_select_pin_i(bank_pin), .ch_enable_o(ch_en),
    .target_mv_o(tmv), .output_discharge_enable_o(dis), .low_bias_enable_o(lowb),
    .host_interrupt_low_o(irq_n)
  );

  rcf_host_model u_host (
    .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .adr_o(adr), .dat_o(wdat),
    .sel_o(sel), .we_o(we), .cyc_o(cyc), .stb_o(stb)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Reference model helpers
  function automatic int mv_of(input int code);
    return BASE_MV[code / 8] + STEP_MV[code / 8] * (code % 8);
  endfunction

  function automatic int mask_of(input int c);
    return (c < RCF_NSW) ? RCF_SW_MASK : RCF_LIN_MASK;
  endfunction

  function automatic logic [3:0] lin_bits(input int b);
    logic [3:0] r;
    for (int l = 0; l < 4; l++) begin
      r[l] = mdl_ctrl[l + RCF_NSW][b];
    end
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input int c, input int ofs, input int d);
    logic [31:0] q;
    u_host.xfer(1'b1, 8'(c * 8 + ofs), 32'(d), 4'hF, q);
    if (ofs == 0)
      mdl_ctrl[c] = d & mask_of(c);
  endtask

  task automatic rd(input int c, input int ofs, output logic [31:0] q);
    u_host.xfer(1'b0, 8'(c * 8 + ofs), 32'h0, 4'hF, q);
  endtask

  task automatic chk_mv(input int c, input int bank);
    int code;
    code = (c < RCF_NSW && bank != 0) ? (mdl_ctrl[c] >> 6) & 63 : mdl_ctrl[c] & 63;
    chk(32'(tmv[c * RCF_MV_W +: RCF_MV_W]), mv_of(code));
  endtask

  task automatic en_ch(input int c, input int irqen);
    wr(c, 0, mdl_ctrl[c] & ~32'h0001F000 | (irqen << RCF_F_IRQEN));
    wr(c, 0, mdl_ctrl[c] | 32'h00001000);
    tick(4);
    chk(32'(ch_en[c]), 1);
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    int          c;
    int          n;
    int          lat;
    rst_i = 1'b1;
    pg_raw = '1;
    bank_pin = 1'b0;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(99));
    for (int i = 0; i < RCF_NCH; i++) begin
      mdl_ctrl[i] = {RCF_DEF_CODE[i], RCF_DEF_CODE[i]} & mask_of(i);
    end
    repeat (3) @(posedge clk_i);
    #1;
    chk(32'(irq_n), 1);
    chk(32'(ch_en), 0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    tick(2);
    for (int i = 0; i < RCF_NCH; i++) begin
      rd(i, 0, q);
      chk(q, mdl_ctrl[i]);
      chk_mv(i, 0);
    end
    // Random codes, both banks, boundary codes
    for (int i = 0; i < 2 * RCF_NCH; i++) begin
      c = i % RCF_NCH;
      @(posedge clk_i);
      bank_pin <= i[0];
      q = (i == 7) ? 32'h0 : (i == 8) ? 32'hFFF : $urandom & 32'h00060FFF;
      wr(c, 0, q);
      rd(c, 0, q);
      chk(q, mdl_ctrl[c]);
      tick(4);
      for (int j = 0; j < RCF_NCH; j++) begin
        chk_mv(j, i % 2);
      end
      chk(32'(lowb), 32'(lin_bits(RCF_F_LOWB)));
      chk(32'(dis), 32'(lin_bits(RCF_F_DIS)));
    end
    // Unmapped places answer zero and keep contents
    for (int i = 0; i < 4; i++) begin
      u_host.xfer(1'b1, BAD_ADR[i], 32'hFFFFFFFF, 4'hF, q);
      u_host.xfer(1'b0, BAD_ADR[i], 32'h0, 4'hF, q);
      chk(q, 0);
    end
    wr(1, 4, 32'hFFFFFFFF);
    // Single byte lane write leaves the other lanes alone
    u_host.xfer(1'b1, 8'h18, 32'hFFFFFFFF, 4'h1, q);
    mdl_ctrl[3] = (mdl_ctrl[3] & ~32'hFF) | (32'hFF & RCF_LIN_MASK);
    for (int i = 0; i < RCF_NCH; i++) begin
      rd(i, 0, q);
      chk(q, mdl_ctrl[i]);
    end
    // Turn-on delay for every code
    for (int k = 0; k < 8; k++) begin
      wr(3, 0, (k << RCF_F_DLY) | 32'h00060000);
      tick(2);
      chk(32'(dis[0]), 1);
      wr(3, 0, mdl_ctrl[3] | 32'h00001000);
      #1;
      n = 0;
      while (ch_en[3] !== 1'b1 && n < 2000) begin
        tick(1);
        n++;
      end
      lat = (k == 0) ? 0 : (MS << k);
      chk(n, lat);
      chk(32'(dis[0]), 0);
      chk(32'(lowb[0]), 1);
      wr(3, 0, mdl_ctrl[3] & ~32'h00001000);
      tick(3);
      chk(32'(ch_en[3]), 0);
      chk(32'(dis[0]), 1);
    end
    // Falling edge while waiting cancels the turn-on
    wr(4, 0, 32'h0000E000);
    wr(4, 0, 32'h0000F000);
    wr(4, 0, 32'h0000E000);
    tick(MS << 8);
    chk(32'(ch_en[4]), 0);
    // Faults, recovery, read and turn-off
    en_ch(0, 1);
    en_ch(5, 1);
    @(posedge clk_i);
    pg_raw[0] <= 1'b0;
    pg_raw[5] <= 1'b0;
    tick(6);
    chk(32'(irq_n), 0);
    rd(5, 4, q);
    chk(q & 7, 6);
    @(posedge clk_i);
    pg_raw[0] <= 1'b1;
    tick(8);
    chk(32'(irq_n), 0);
    rd(0, 4, q);
    chk(q & 7, 7);
    tick(6);
    chk(32'(irq_n), 0);
    wr(5, 0, mdl_ctrl[5] & ~32'h00001000);
    tick(6);
    chk(32'(irq_n), 1);
    // Masked fault and fault on an idle channel
    en_ch(6, 0);
    wr(2, 0, 32'h00010000);
    @(posedge clk_i);
    pg_raw[6] <= 1'b0;
    pg_raw[2] <= 1'b0;
    tick(8);
    chk(32'(irq_n), 1);
    rd(2, 4, q);
    chk(q & 7, 0);
    end_of_test();
  end
endmodule // rcf_regulator_ctrl_tb
